// ---- src/lpc_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module lpc_top
  import lpc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        fast_rc_clock_i,
  input  wire logic        secondary_osc_clock_i,
  input  wire logic        low_power_rc_clock_i,
  input  wire logic        secondary_osc_enable_i,
  input  wire logic        sleep_i,
  input  wire logic        interval_a_i,
  input  wire logic [2:0]  com_sel_i,
  output logic      [63:0] seg_dark_o,
  output logic             frame_tick_o,
  output logic             display_active_flag_o,
  output lpc_bias_t        bias_type_o,
  output logic             ladder_low_o,
  output logic             ladder_med_o,
  output logic             ladder_high_o,
  output logic             ladder_connect_o,
  output logic             bias_from_core_o,
  output logic      [2:0]  contrast_select_o
);
  function automatic logic pix_hit(input logic [11:0] adr);
    pix_hit = (adr >= ADR_PIX_BASE) && (adr <= ADR_PIX_LAST);
  endfunction : pix_hit

  function automatic logic [5:0] pix_index(input logic [11:0] adr);
    logic [11:0] off;
    off = adr - ADR_PIX_BASE;
    pix_index = off[7:2];
  endfunction : pix_index

  logic [7:0]  pix_q [PIX_COUNT];
  logic [7:0]  display_control_register_q;
  logic [7:0]  phase_prescale_register_q;
  logic [7:0]  reference_control_register_q;
  logic [7:0]  ladder_power_control_q;
  logic [7:0]  ref_source_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        active_q;
  logic        active_d;
  logic        req;
  logic        wr;
  logic [1:0]  clk_src;
  logic [2:0]  mux_sel;
  logic [7:0]  wbyte;
  logic [63:0] dark_q;
  lpc_bias_t   bias_q;
  lpc_bias_t   bias_d;

  lpc_cfg_if cfg ();

  assign req     = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr      = req && wb_we_i && wb_sel_i[0];
  assign wbyte   = wb_dat_i[7:0];
  assign clk_src = display_control_register_q[CTRL_CS_LSB +: 2];
  assign mux_sel = display_control_register_q[CTRL_MUX_LSB +: 3];

  // Bus handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      display_control_register_q   <= RESET_BYTE;
      phase_prescale_register_q    <= RESET_BYTE;
      reference_control_register_q <= RESET_BYTE;
      ladder_power_control_q       <= RESET_BYTE;
      ref_source_q                 <= RESET_BYTE;
    end else if (wr) begin
      unique case (wb_adr_i)
        ADR_CTRL:   display_control_register_q   <= wbyte & CTRL_WMASK;
        ADR_PHASE:  phase_prescale_register_q    <= wbyte & PHASE_WMASK;
        ADR_REF:    reference_control_register_q <= wbyte & REF_WMASK;
        ADR_LADDER: ladder_power_control_q       <= wbyte & LADDER_WMASK;
        ADR_SRCSEL: ref_source_q                 <= wbyte & SRC_WMASK;
        default: ;
      endcase
    end
  end

  // Pixel store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < PIX_COUNT; i++) begin
        pix_q[i] <= RESET_BYTE;
      end
    end else if (wr && pix_hit(wb_adr_i)) begin
      pix_q[pix_index(wb_adr_i)] <= wbyte;
    end
  end

  // Read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 32'h00000000;
    end else if (req) begin
      rdata_q <= 32'h00000000;
      if (pix_hit(wb_adr_i)) begin
        rdata_q[7:0] <= pix_q[pix_index(wb_adr_i)];
      end else begin
        unique case (wb_adr_i)
          ADR_CTRL:   rdata_q[7:0] <= display_control_register_q;
          ADR_PHASE: begin
            rdata_q[7:0]          <= phase_prescale_register_q;
            rdata_q[PH_ACTIVE_BIT] <= active_q;
          end
          ADR_REF:    rdata_q[7:0] <= reference_control_register_q;
          ADR_LADDER: rdata_q[7:0] <= ladder_power_control_q;
          ADR_SRCSEL: rdata_q[7:0] <= ref_source_q;
          default: ;
        endcase
      end
    end
  end

  // Active status
  always_comb begin
    active_d = display_control_register_q[CTRL_EN_BIT];
    if (sleep_i && (display_control_register_q[CTRL_SLP_BIT] || clk_src == CS_FAST)) begin
      active_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  // Bias type
  always_comb begin
    if (mux_sel == MUX_STATIC) begin
      bias_d = LPC_BIAS_STATIC;
    end else if (mux_sel <= MUX_THREE && phase_prescale_register_q[PH_BIASMD_BIT]) begin
      bias_d = LPC_BIAS_HALF;
    end else begin
      bias_d = LPC_BIAS_THIRD;
    end
  end

  // Segment drive for the selected common
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dark_q <= 64'h0000000000000000;
      bias_q <= LPC_BIAS_STATIC;
    end else begin
      bias_q <= bias_d;
      for (int k = 0; k < PIX_GROUP; k++) begin
        dark_q[k*PIX_GROUP +: PIX_GROUP] <= pix_q[{com_sel_i, 3'(k)}];
      end
    end
  end

  assign cfg.clk_src    = clk_src;
  assign cfg.prescale   = phase_prescale_register_q[PH_LP_LSB +: 4];
  assign cfg.active     = active_q;
  assign cfg.ref_en     = reference_control_register_q[REF_EN_BIT];
  assign cfg.ref_core   = ref_source_q[SRC_CORE_BIT];
  assign cfg.interval_a = interval_a_i;
  assign cfg.pwr_a      = ladder_power_control_q[LAD_AP_LSB +: 2];
  assign cfg.pwr_b      = ladder_power_control_q[LAD_BP_LSB +: 2];
  assign cfg.contrast   = reference_control_register_q[REF_CST_LSB +: 3];

  lpc_clock_div u_div (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .fast_rc_clock_i        (fast_rc_clock_i),
    .secondary_osc_clock_i  (secondary_osc_clock_i),
    .low_power_rc_clock_i   (low_power_rc_clock_i),
    .secondary_osc_enable_i (secondary_osc_enable_i),
    .cfg                    (cfg)
  );

  lpc_ladder u_ladder (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cfg   (cfg)
  );

  assign wb_ack_o              = ack_q;
  assign wb_dat_o              = rdata_q;
  assign seg_dark_o            = dark_q;
  assign bias_type_o           = bias_q;
  assign frame_tick_o          = cfg.frame_tick;
  assign display_active_flag_o = active_q;
  assign ladder_low_o          = cfg.lad_low;
  assign ladder_med_o          = cfg.lad_med;
  assign ladder_high_o         = cfg.lad_high;
  assign ladder_connect_o      = cfg.lad_connect;
  assign bias_from_core_o      = cfg.bias_core;
  assign contrast_select_o     = cfg.contrast_out;

  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !ack_q) |=> ack_q ##1 !ack_q;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack not a single cycle");

  property p_pix_store;
    @(posedge clk_i) disable iff (rst_i)
    (wr && pix_hit(wb_adr_i)) |=> pix_q[pix_index($past(wb_adr_i))] == $past(wbyte);
  endproperty
  a_pix_store: assert property (p_pix_store) else $error("pixel byte not stored");

  property p_dark_map;
    @(posedge clk_i) disable iff (rst_i)
    !wr |=> dark_q[PIX_GROUP +: PIX_GROUP] == pix_q[{$past(com_sel_i), 3'h1}];
  endproperty
  a_dark_map: assert property (p_dark_map) else $error("segment byte mapping wrong");

  property p_sleep_fast;
    @(posedge clk_i) disable iff (rst_i)
    (sleep_i && clk_src == CS_FAST) |=> !active_q;
  endproperty
  a_sleep_fast: assert property (p_sleep_fast) else $error("fast source active in sleep");

  property p_sleep_slow;
    @(posedge clk_i) disable iff (rst_i)
    (display_control_register_q[CTRL_EN_BIT] && !display_control_register_q[CTRL_SLP_BIT]
      && clk_src != CS_FAST) |=> active_q;
  endproperty
  a_sleep_slow: assert property (p_sleep_slow) else $error("slow source stopped");

  property p_pix_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && pix_hit(wb_adr_i)) |=> rdata_q[7:0] == pix_q[pix_index($past(wb_adr_i))];
  endproperty
  a_pix_read: assert property (p_pix_read) else $error("pixel byte read wrong");

  property p_rdata_upper;
    @(posedge clk_i) disable iff (rst_i)
    ack_q |-> rdata_q[31:8] == 24'h000000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("read data upper bits set");

  property p_ack_idle;
    @(posedge clk_i) disable iff (rst_i)
    !(wb_cyc_i && wb_stb_i) |=> !ack_q;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("ack without request");

  property p_ctrl_write;
    @(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ADR_CTRL) |=> clk_src == $past(wbyte[CTRL_CS_LSB +: 2]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("source field not stored");

  property p_prescale_write;
    @(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ADR_PHASE) |=> cfg.prescale == $past(wbyte[PH_LP_LSB +: 4]);
  endproperty
  a_prescale_write: assert property (p_prescale_write) else $error("prescale not stored");

  property p_bias_static;
    @(posedge clk_i) disable iff (rst_i)
    (mux_sel == MUX_STATIC) |=> bias_q == LPC_BIAS_STATIC;
  endproperty
  a_bias_static: assert property (p_bias_static) else $error("static bias wrong");

  property p_bias_third;
    @(posedge clk_i) disable iff (rst_i)
    (mux_sel > MUX_THREE) |=> bias_q == LPC_BIAS_THIRD;
  endproperty
  a_bias_third: assert property (p_bias_third) else $error("third bias wrong");

  property p_bias_half;
    @(posedge clk_i) disable iff (rst_i)
    (mux_sel != MUX_STATIC && mux_sel <= MUX_THREE && phase_prescale_register_q[PH_BIASMD_BIT])
      |=> bias_q == LPC_BIAS_HALF;
  endproperty
  a_bias_half: assert property (p_bias_half) else $error("half bias wrong");

  property p_sleep_disable;
    @(posedge clk_i) disable iff (rst_i)
    (sleep_i && display_control_register_q[CTRL_SLP_BIT]) |=> !active_q;
  endproperty
  a_sleep_disable: assert property (p_sleep_disable) else $error("active in sleep");

  property p_active_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && wb_adr_i == ADR_PHASE) |=> rdata_q[PH_ACTIVE_BIT] == $past(active_q);
  endproperty
  a_active_read: assert property (p_active_read) else $error("active flag read wrong");

  property p_dark_zero;
    @(posedge clk_i) disable iff (rst_i)
    (pix_q[{com_sel_i, 3'h0}] == RESET_BYTE) |=> dark_q[0 +: PIX_GROUP] == RESET_BYTE;
  endproperty
  a_dark_zero: assert property (p_dark_zero) else $error("clear pixel driven dark");
endmodule : lpc_top
`default_nettype wire

// ---- src/lpc_pkg.sv ----
package lpc_pkg;
  localparam logic [11:0] ADR_CTRL     = 12'h000;
  localparam logic [11:0] ADR_PHASE    = 12'h004;
  localparam logic [11:0] ADR_REF      = 12'h008;
  localparam logic [11:0] ADR_LADDER   = 12'h00C;
  localparam logic [11:0] ADR_SRCSEL   = 12'h010;
  localparam logic [11:0] ADR_PIX_BASE = 12'h100;
  localparam logic [11:0] ADR_PIX_LAST = 12'h1FC;
  localparam int          PIX_COUNT    = 64;
  localparam int          PIX_GROUP    = 8;

  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_SLP_BIT  = 6;
  localparam int CTRL_CS_LSB   = 3;
  localparam int CTRL_MUX_LSB  = 0;
  localparam int PH_BIASMD_BIT = 6;
  localparam int PH_ACTIVE_BIT = 5;
  localparam int PH_LP_LSB     = 0;
  localparam int REF_EN_BIT    = 7;
  localparam int REF_CST_LSB   = 3;
  localparam int LAD_AP_LSB    = 6;
  localparam int LAD_BP_LSB    = 4;
  localparam int SRC_CORE_BIT  = 0;

  localparam logic [7:0] CTRL_WMASK   = 8'hDF;
  localparam logic [7:0] PHASE_WMASK  = 8'hCF;
  localparam logic [7:0] REF_WMASK    = 8'hBF;
  localparam logic [7:0] LADDER_WMASK = 8'hF7;
  localparam logic [7:0] SRC_WMASK    = 8'h01;
  localparam logic [7:0] RESET_BYTE   = 8'h00;

  localparam logic [1:0] CS_FAST = 2'h0;
  localparam logic [1:0] CS_SECONDARY_OSC_CLOCK = 2'h1;
  localparam logic [2:0] MUX_STATIC = 3'h0;
  localparam logic [2:0] MUX_THREE  = 3'h2;

  localparam logic [1:0] PWR_OFF  = 2'h0;
  localparam logic [1:0] PWR_LOW  = 2'h1;
  localparam logic [1:0] PWR_MED  = 2'h2;
  localparam logic [1:0] PWR_HIGH = 2'h3;

  localparam int FAST_DIV = 8192;
  localparam int SLOW_DIV = 32;

  typedef enum logic [1:0] {
    LPC_BIAS_STATIC,
    LPC_BIAS_HALF,
    LPC_BIAS_THIRD
  } lpc_bias_t;
endpackage : lpc_pkg

// ---- src/lpc_cfg_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface lpc_cfg_if;
  logic [1:0] clk_src;
  logic [3:0] prescale;
  logic       active;
  logic       frame_tick;
  logic       ref_en;
  logic       ref_core;
  logic       interval_a;
  logic [1:0] pwr_a;
  logic [1:0] pwr_b;
  logic [2:0] contrast;
  logic       lad_low;
  logic       lad_med;
  logic       lad_high;
  logic       lad_connect;
  logic       bias_core;
  logic [2:0] contrast_out;

  modport clk_mp (input clk_src, prescale, active, output frame_tick);
  modport lad_mp (input active, ref_en, ref_core, interval_a, pwr_a, pwr_b, contrast,
                  output lad_low, lad_med, lad_high, lad_connect, bias_core, contrast_out);
endinterface : lpc_cfg_if
`default_nettype wire

// ---- src/lpc_clock_div.sv ----
`timescale 1ns/10ps
`default_nettype none
module lpc_clock_div
  import lpc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic fast_rc_clock_i,
  input  wire logic secondary_osc_clock_i,
  input  wire logic low_power_rc_clock_i,
  input  wire logic secondary_osc_enable_i,
  lpc_cfg_if.clk_mp cfg
);
  logic [2:0]  prev_q;
  logic [1:0]  src_q;
  logic [12:0] pre_cnt_q;
  logic [15:0] psc_cnt_q;
  logic        src_edge;
  logic        pre_tick;
  logic [12:0] pre_term;
  logic        tick_q;

  always_comb begin
    unique case (cfg.clk_src)
      CS_FAST: src_edge = fast_rc_clock_i & ~prev_q[0];
      CS_SECONDARY_OSC_CLOCK: src_edge = secondary_osc_clock_i & ~prev_q[1] & secondary_osc_enable_i;
      default: src_edge = low_power_rc_clock_i & ~prev_q[2];
    endcase
  end

  assign pre_term = (cfg.clk_src == CS_FAST) ? 13'(FAST_DIV - 1) : 13'(SLOW_DIV - 1);
  assign pre_tick = src_edge && (pre_cnt_q == pre_term);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 3'h0;
    end else begin
      prev_q <= {low_power_rc_clock_i, secondary_osc_clock_i, fast_rc_clock_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_q     <= CS_FAST;
      pre_cnt_q <= 13'h0000;
    end else begin
      src_q <= cfg.clk_src;
      if (!cfg.active || src_q != cfg.clk_src) begin
        pre_cnt_q <= 13'h0000;
      end else if (src_edge) begin
        pre_cnt_q <= pre_tick ? 13'h0000 : pre_cnt_q + 13'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psc_cnt_q <= 16'h0000;
      tick_q    <= 1'b0;
    end else begin
      tick_q <= cfg.active && pre_tick && (psc_cnt_q == 16'(cfg.prescale));
      if (!cfg.active) begin
        psc_cnt_q <= 16'h0000;
      end else if (pre_tick) begin
        psc_cnt_q <= (psc_cnt_q == 16'(cfg.prescale)) ? 16'h0000 : psc_cnt_q + 16'h0001;
      end
    end
  end

  assign cfg.frame_tick = tick_q;

  property p_tick_at_ratio;
    @(posedge clk_i) disable iff (rst_i)
    (cfg.active && pre_tick && psc_cnt_q == 16'(cfg.prescale)) |=> tick_q ##1 !tick_q;
  endproperty
  a_tick_at_ratio: assert property (p_tick_at_ratio) else $error("frame tick missed");

  property p_psc_restart;
    @(posedge clk_i) disable iff (rst_i)
    $rose(tick_q) |-> (psc_cnt_q == 16'h0000) && $past(psc_cnt_q) <= 16'h000F;
  endproperty
  a_psc_restart: assert property (p_psc_restart) else $error("prescaler did not restart");

  property p_fast_fixed;
    @(posedge clk_i) disable iff (rst_i)
    (cfg.active && src_q == CS_FAST && cfg.clk_src == CS_FAST && pre_tick)
      |-> $past(pre_cnt_q) == 13'(FAST_DIV - 2) || $past(pre_cnt_q) == 13'(FAST_DIV - 1);
  endproperty
  a_fast_fixed: assert property (p_fast_fixed) else $error("fast divider not 8192");
endmodule : lpc_clock_div
`default_nettype wire

// ---- src/lpc_ladder.sv ----
`timescale 1ns/10ps
`default_nettype none
module lpc_ladder
  import lpc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  lpc_cfg_if.lad_mp cfg
);
  logic [1:0] pwr;
  logic       on;
  logic       low_q;
  logic       med_q;
  logic       high_q;
  logic       conn_q;
  logic       core_q;
  logic [2:0] cst_q;

  assign pwr = cfg.interval_a ? cfg.pwr_a : cfg.pwr_b;
  assign on  = cfg.active && cfg.ref_en && (pwr != PWR_OFF);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_q  <= 1'b0;
      med_q  <= 1'b0;
      high_q <= 1'b0;
      conn_q <= 1'b0;
    end else begin
      conn_q <= on;
      low_q  <= on && (pwr == PWR_LOW);
      med_q  <= on && (pwr == PWR_MED || (cfg.interval_a && pwr == PWR_HIGH));
      high_q <= on && (pwr == PWR_HIGH);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_q <= 1'b0;
      cst_q  <= 3'h0;
    end else begin
      core_q <= cfg.ref_core;
      cst_q  <= cfg.contrast;
    end
  end

  assign cfg.lad_low      = low_q;
  assign cfg.lad_med      = med_q;
  assign cfg.lad_high     = high_q;
  assign cfg.lad_connect  = conn_q;
  assign cfg.bias_core    = core_q;
  assign cfg.contrast_out = cst_q;

  property p_inactive_off;
    @(posedge clk_i) disable iff (rst_i)
    !cfg.active |=> !conn_q && !low_q && !med_q && !high_q;
  endproperty
  a_inactive_off: assert property (p_inactive_off) else $error("ladder on while inactive");

  property p_a_high_both;
    @(posedge clk_i) disable iff (rst_i)
    (cfg.active && cfg.ref_en && cfg.interval_a && cfg.pwr_a == PWR_HIGH) |=> med_q && high_q;
  endproperty
  a_a_high_both: assert property (p_a_high_both) else $error("mode A high lacks medium");

  property p_zero_off;
    @(posedge clk_i) disable iff (rst_i)
    (pwr == PWR_OFF || !cfg.ref_en) |=> !conn_q;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("ladder connected when off");
endmodule : lpc_ladder
`default_nettype wire

// ---- verif/lpc_glass_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module lpc_glass_model (
  input  wire logic        clk_i,
  input  wire logic [2:0]  com_sel_i,
  input  wire logic [63:0] seg_dark_i,
  output logic [7:0][63:0] image_o
);
  logic [2:0] com_q;

  // Panel image per common, one cycle behind the common select
  always_ff @(posedge clk_i) begin
    com_q          <= com_sel_i;
    image_o[com_q] <= seg_dark_i;
  end
endmodule : lpc_glass_model
`default_nettype wire

// ---- verif/lpc_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module lpc_top_tb;
  import lpc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, secondary_osc_clock_en = 1'b1, sleep_i = 1'b0, ia_i = 1'b0, frame_tick_o, active_o;
  logic [2:0] run = 3'h0, src = 3'h0, com_sel_i = 3'h0, contrast_o;
  logic [63:0] seg_dark_o;
  logic [7:0][63:0] image;
  lpc_bias_t bias_o;
  logic lad_low, lad_med, lad_high, lad_conn, core_o;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #2.5 clk_i = ~clk_i;
  // Source clocks toggle every cycle while running
  always @(posedge clk_i) src <= run & ~src;

  lpc_top lpc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fast_rc_clock_i(src[0]),
    .secondary_osc_clock_i(src[1]), .low_power_rc_clock_i(src[2]),
    .secondary_osc_enable_i(secondary_osc_clock_en), .sleep_i(sleep_i), .interval_a_i(ia_i),
    .com_sel_i(com_sel_i), .seg_dark_o(seg_dark_o), .frame_tick_o(frame_tick_o),
    .display_active_flag_o(active_o), .bias_type_o(bias_o), .ladder_low_o(lad_low),
    .ladder_med_o(lad_med), .ladder_high_o(lad_high), .ladder_connect_o(lad_conn),
    .bias_from_core_o(core_o), .contrast_select_o(contrast_o));

  lpc_glass_model lpc_glass_model_i (.clk_i(clk_i), .com_sel_i(com_sel_i),
    .seg_dark_i(seg_dark_o), .image_o(image));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wb(input logic [11:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_mismatch++;
      $display("unexpected at %0t: bus ack timeout", $time);
      print_verdict();
    end
    @(posedge clk_i);
  endtask : wb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] q);
    wb(a, 1'b0, 8'h00, q);
  endtask : rd

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 37 + 1);
  endfunction : pat

  task automatic t_regs();
    logic [11:0] adr[5] = '{ADR_CTRL, ADR_PHASE, ADR_REF, ADR_LADDER, ADR_SRCSEL};
    logic [7:0] msk[5] = '{CTRL_WMASK, PHASE_WMASK, REF_WMASK, LADDER_WMASK, SRC_WMASK};
    logic [7:0] q;
    chk(seg_dark_o, 64'h0, "segments after reset");
    chk({frame_tick_o, active_o, bias_o, lad_low, lad_med, lad_high, lad_conn}, 64'h0,
        "status after reset");
    for (int i = 0; i < 5; i++) begin
      rd(adr[i], q);
      chk(q, RESET_BYTE, "config reset value");
    end
    for (int i = 0; i < 5; i++) begin
      wr(adr[i], 8'hFF);
    end
    for (int i = 0; i < 5; i++) begin
      rd(adr[i], q);
      chk(q, msk[i] | ((i == 1) ? 8'h20 : 8'h00), "config readback");
    end
    for (int i = 0; i < 5; i++) begin
      wr(adr[i], 8'h00);
    end
    wb_sel_i <= 4'hE;
    wr(ADR_LADDER, 8'hFF);
    wb_sel_i <= 4'hF;
    rd(ADR_LADDER, q);
    chk(q, 8'h00, "write without byte select");
    wr(12'h020, 8'hFF);
    rd(12'h020, q);
    chk(q, 8'h00, "unmapped read");
    $display("test regs done");
  endtask : t_regs

  task automatic t_pixels();
    logic [7:0] q;
    logic [63:0] e;
    for (int i = 0; i < PIX_COUNT; i++) begin
      rd(ADR_PIX_BASE + 12'(4 * i), q);
      chk(q, 8'h00, "pixel reset");
      wr(ADR_PIX_BASE + 12'(4 * i), pat(i));
    end
    for (int i = 0; i < PIX_COUNT; i++) begin
      rd(ADR_PIX_BASE + 12'(4 * i), q);
      chk(q, pat(i), "pixel readback");
    end
    for (int c = 0; c < 8; c++) begin
      com_sel_i <= 3'(c);
      repeat (3) @(posedge clk_i);
    end
    for (int c = 0; c < 8; c++) begin
      for (int k = 0; k < 8; k++) e[8*k +: 8] = pat(8 * c + k);
      chk(image[c], e, "glass image per common");
    end
    $display("test pixels done");
  endtask : t_pixels

  task automatic run_src(input logic [7:0] ctl, input logic [3:0] p, input logic [2:0] r,
                         input int cyc, input int n);
    int t = 0;
    wr(ADR_CTRL, 8'h00);
    wr(ADR_PHASE, {4'h0, p});
    run <= r;
    wr(ADR_CTRL, ctl);
    repeat (cyc) begin
      @(posedge clk_i);
      if (frame_tick_o === 1'b1) t++;
    end
    run <= 3'h0;
    chk(64'(t), 64'(n), "frame tick count");
  endtask : run_src

  task automatic t_clock();
    run_src(8'h80, 4'h0, 3'b001, 24576, 1);
    run_src(8'h88, 4'h3, 3'b010, 640, 2);
    run_src(8'h90, 4'hF, 3'b100, 1536, 1);
    run_src(8'h98, 4'h0, 3'b100, 224, 3);
    run_src(8'h90, 4'h0, 3'b001, 200, 0);
    secondary_osc_clock_en <= 1'b0;
    run_src(8'h88, 4'h0, 3'b010, 200, 0);
    secondary_osc_clock_en <= 1'b1;
    sleep_i <= 1'b1;
    run_src(8'h90, 4'h1, 3'b100, 320, 2);
    chk(active_o, 1'b1, "active in sleep on slow source");
    wr(ADR_CTRL, 8'h80);
    repeat (2) @(posedge clk_i);
    chk(active_o, 1'b0, "fast source stops in sleep");
    wr(ADR_CTRL, 8'hD0);
    repeat (2) @(posedge clk_i);
    chk(active_o, 1'b0, "sleep disable bit");
    sleep_i <= 1'b0;
    $display("test clock done");
  endtask : t_clock

  task automatic t_ladder();
    logic [1:0] e;
    wr(ADR_SRCSEL, 8'h01);
    wr(ADR_CTRL, 8'h80);
    for (int c = 0; c < 4; c++) begin
      for (int a = 0; a < 2; a++) begin
        ia_i <= 1'(a);
        wr(ADR_LADDER, {2'(c), ~2'(c), 4'h0});
        wr(ADR_REF, {2'b10, 2'(c), 1'(a), 3'b000});
        repeat (2) @(posedge clk_i);
        e = a ? 2'(c) : ~2'(c);
        chk({lad_low, lad_med, lad_high, lad_conn}, {e == PWR_LOW, e == PWR_MED ||
            (e == PWR_HIGH && a == 1), e == PWR_HIGH, e != PWR_OFF}, "ladder");
        chk({core_o, contrast_o}, {1'b1, 2'(c), 1'(a)}, "bias source contrast");
      end
    end
    wr(ADR_REF, 8'h00);
    repeat (2) @(posedge clk_i);
    chk({lad_low, lad_med, lad_high, lad_conn}, 4'h0, "reference off");
    wr(ADR_REF, 8'h80);
    wr(ADR_CTRL, 8'h00);
    repeat (2) @(posedge clk_i);
    chk({lad_low, lad_med, lad_high, lad_conn}, 4'h0, "inactive ladders");
    $display("test ladder done");
  endtask : t_ladder

  task automatic t_bias();
    logic [2:0] mux[5] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h7};
    logic md[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    lpc_bias_t ex[5] = '{LPC_BIAS_STATIC, LPC_BIAS_HALF, LPC_BIAS_HALF, LPC_BIAS_THIRD,
                         LPC_BIAS_THIRD};
    for (int i = 0; i < 5; i++) begin
      wr(ADR_PHASE, {1'b0, md[i], 6'h00});
      wr(ADR_CTRL, {5'h10, mux[i]});
      repeat (2) @(posedge clk_i);
      chk(bias_o, ex[i], "bias type");
    end
    $display("test bias done");
  endtask : t_bias

  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_regs();
    t_pixels();
    t_clock();
    t_ladder();
    t_bias();
    print_verdict();
  end
endmodule : lpc_top_tb
`default_nettype wire
